// ### hdl/deoc_pkg.sv
// deoc_pkg: constants, carriers and state names for the draw engine operation control.
// assumes: one 10 MHz clock; every host access arrives as a one-cycle strobe.
package deoc_pkg;

	localparam int WORD_W = 32;
	localparam int PIX_W = 8;
	localparam int PTR_W = 8;
	localparam int LEN_A = 16;
	localparam int LEN_B = 16;
	localparam int FIFO_DEPTH = 8;

	// control register bit positions
	localparam int CTRL_BUSY_BIT = 7;
	localparam int CTRL_ABORT_BIT = 5;
	localparam int CTRL_HALTED_BIT = 4;
	localparam int CTRL_SUSP_BIT = 3;

	// colour compare condition codes (true inhibits the destination write)
	localparam logic [2:0] CMP_ALWAYS = 3'h0;
	localparam logic [2:0] CMP_GT = 3'h1;
	localparam logic [2:0] CMP_EQ = 3'h2;
	localparam logic [2:0] CMP_LT = 3'h3;
	localparam logic [2:0] CMP_NEVER = 3'h4;
	localparam logic [2:0] CMP_GE = 3'h5;
	localparam logic [2:0] CMP_NE = 3'h6;
	localparam logic [2:0] CMP_LE = 3'h7;

	localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_HALTED
	} deoc_state_e;

	// host write to the control register
	typedef struct packed {
		logic suspend;
		logic abort;
	} deoc_ctrl_s;

	// one destination pixel offered for the compare test
	typedef struct packed {
		logic valid;
		logic [2:0] cond;
		logic [PIX_W-1:0] dest;
		logic [PIX_W-1:0] value;
	} deoc_pix_s;

endpackage

// ### hdl/deoc_fifo.sv
// deoc_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes: one clock, synchronous active-low reset, clock enable freezes all state.
`timescale 1ns/10ps
`default_nettype none
module deoc_fifo #(
	parameter int W = 33,
	parameter int DEPTH = 8
) (
	input wire logic clk, // clock
	input wire logic reset_n, // sync reset, active low
	input wire logic clk_en, // freezes state when low
	input wire logic in_valid, // producer has a word
	output logic in_ready, // room for a word
	input wire logic [W-1:0] in_data, // word in
	output logic out_valid, // a word waits
	input wire logic out_ready, // consumer takes the word
	output logic [W-1:0] out_data // oldest word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} deoc_fifo_s;

	deoc_fifo_s s_q, s_d;
	logic push, pop;

	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];

	always_comb begin
		s_d = s_q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule // deoc_fifo
`default_nettype wire

// ### hdl/deoc_op_control.sv
// deoc_op_control: start, suspend, resume and terminate of drawing operations,
// completion and rejected-write status with interrupt, colour compare inhibit,
// and state save/restore through two 32-bit ports with length counts.
// assumes: host accesses arrive as one-cycle strobes; the datapath reports
// memory cycles in flight and the last pixel of an operation.
`timescale 1ns/10ps
`default_nettype none
module deoc_op_control #(
	parameter int LEN_A = deoc_pkg::LEN_A,
	parameter int LEN_B = deoc_pkg::LEN_B,
	parameter int FIFO_DEPTH = deoc_pkg::FIFO_DEPTH
) (
	input wire logic clk, // 10 MHz clock
	input wire logic reset_n, // sync reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic host_wr, // any engine register write
	input wire logic host_wr_ctrl, // write hits the control register
	input wire logic host_wr_start, // write hits pixel-op top byte
	input wire deoc_pkg::deoc_ctrl_s ctrl_wdata, // control write data
	input wire logic irq_en_wr, // load interrupt enables
	input wire logic irq_en_done_in, // enable for completion
	input wire logic irq_en_rej_in, // enable for rejected access
	input wire logic clr_done, // write-one-clear completion status
	input wire logic clr_rej, // write-one-clear rejected status
	input wire logic mem_busy, // datapath memory cycle in flight
	input wire logic op_last, // datapath finished last pixel
	input wire deoc_pkg::deoc_pix_s pix, // pixel for compare
	input wire logic port_a_rd, // host reads state port a
	input wire logic port_b_rd, // host reads state port b
	input wire logic port_a_wr, // host writes state port a
	input wire logic port_b_wr, // host writes state port b
	input wire logic [deoc_pkg::WORD_W-1:0] port_wdata, // restore word
	input wire logic eng_we, // datapath stores hidden state
	input wire logic eng_sel_b, // datapath picks bank b
	input wire logic [deoc_pkg::PTR_W-1:0] eng_idx, // datapath state index
	input wire logic [deoc_pkg::WORD_W-1:0] eng_wdata, // datapath state word
	output logic [7:0] ctrl_rdata, // control register readback
	output logic engine_active_flag, // operation executing
	output logic halted_flag, // suspension took effect
	output logic abort_request, // terminate in progress
	output logic done_status, // operation complete status
	output logic rej_status, // access rejected status
	output logic irq, // interrupt to host
	output logic tlb_flush, // one-cycle translation buffer flush
	output logic run_en, // datapath may advance
	output logic write_inhibit, // skip this destination write
	output logic [deoc_pkg::WORD_W-1:0] port_a_rdata, // save word, port a
	output logic [deoc_pkg::WORD_W-1:0] port_b_rdata, // save word, port b
	output logic restore_ready, // restore buffer has room
	output logic [deoc_pkg::PTR_W-1:0] len_a, // doublewords through port a
	output logic [deoc_pkg::PTR_W-1:0] len_b, // doublewords through port b
	output logic [deoc_pkg::WORD_W-1:0] eng_rdata // state word to datapath
);
	localparam int W = deoc_pkg::WORD_W;
	localparam int PW = deoc_pkg::PTR_W;
	localparam logic [PW-1:0] LA = PW'(LEN_A);
	localparam logic [PW-1:0] LB = PW'(LEN_B);

	typedef struct packed {
		deoc_pkg::deoc_state_e st;
		logic susp;
		logic abort;
		logic halted;
		logic busy;
		logic run;
		logic done;
		logic rej;
		logic en_done;
		logic en_rej;
		logic irq;
		logic tlb;
		logic inhibit;
		logic [PW-1:0] rd_a;
		logic [PW-1:0] rd_b;
		logic [PW-1:0] wr_a;
		logic [PW-1:0] wr_b;
		logic [W-1:0] dout_a;
		logic [W-1:0] dout_b;
		logic [W-1:0] eng_out;
		logic [LEN_A-1:0][W-1:0] bank_a;
		logic [LEN_B-1:0][W-1:0] bank_b;
	} deoc_core_s;

	deoc_core_s s_q, s_d;

	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [W:0] fifo_out_data;

	// restore words queue here so host writes never wait on the bank port
	deoc_fifo #(
		.W(W + 1),
		.DEPTH(FIFO_DEPTH)
	) u_restore_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({port_b_wr, port_wdata}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	function automatic logic cmp_true(input deoc_pkg::deoc_pix_s p);
		case (p.cond)
			deoc_pkg::CMP_ALWAYS: cmp_true = 1'b1;
			deoc_pkg::CMP_GT: cmp_true = p.dest > p.value;
			deoc_pkg::CMP_EQ: cmp_true = p.dest == p.value;
			deoc_pkg::CMP_LT: cmp_true = p.dest < p.value;
			deoc_pkg::CMP_NEVER: cmp_true = 1'b0;
			deoc_pkg::CMP_GE: cmp_true = p.dest >= p.value;
			deoc_pkg::CMP_NE: cmp_true = p.dest != p.value;
			deoc_pkg::CMP_LE: cmp_true = p.dest <= p.value;
			default: cmp_true = 1'b0;
		endcase
	endfunction

	// restore writes are refused while running; the host still sees them rejected
	assign fifo_in_valid = (port_a_wr || port_b_wr) && (s_q.st != deoc_pkg::ST_RUN);
	// drain stalls on a save read so the bank sees one access per cycle
	assign fifo_out_ready = (s_q.st != deoc_pkg::ST_RUN) && !port_a_rd && !port_b_rd;

	always_comb begin
		logic op_end;
		logic set_done;
		logic set_rej;
		op_end = 1'b0;
		set_done = 1'b0;
		set_rej = 1'b0;
		s_d = s_q;
		s_d.tlb = 1'b0;
		s_d.inhibit = pix.valid && cmp_true(pix);

		if (irq_en_wr) begin
			s_d.en_done = irq_en_done_in;
			s_d.en_rej = irq_en_rej_in;
		end

		// while busy, host writes other than to the control register raise the rejected flag
		if (host_wr && s_q.busy && !host_wr_ctrl) begin
			set_rej = 1'b1;
		end

		if (host_wr_ctrl) begin
			s_d.susp = ctrl_wdata.suspend;
			if (ctrl_wdata.abort) begin
				s_d.abort = 1'b1;
			end
		end

		case (s_q.st)
			deoc_pkg::ST_IDLE: begin
				if (host_wr_start && !s_q.abort) begin
					s_d.st = deoc_pkg::ST_RUN;
					s_d.busy = 1'b1;
				end
			end
			deoc_pkg::ST_RUN: begin
				if (op_last) begin
					s_d.st = deoc_pkg::ST_IDLE;
					s_d.busy = 1'b0;
					op_end = 1'b1;
				end else if (s_q.susp && !mem_busy) begin
					s_d.st = deoc_pkg::ST_HALTED;
					s_d.busy = 1'b0;
					s_d.halted = 1'b1;
					s_d.tlb = 1'b1;
					s_d.rd_a = deoc_pkg::PTR_RESET;
					s_d.rd_b = deoc_pkg::PTR_RESET;
					s_d.wr_a = deoc_pkg::PTR_RESET;
					s_d.wr_b = deoc_pkg::PTR_RESET;
				end
			end
			deoc_pkg::ST_HALTED: begin
				// a halted operation cannot be restarted by a new start, only resumed
				if (!s_q.susp) begin
					s_d.st = deoc_pkg::ST_RUN;
					s_d.busy = 1'b1;
					s_d.halted = 1'b0;
				end
			end
			default: begin
				s_d.st = deoc_pkg::ST_IDLE;
			end
		endcase

		// save: each read hands out the next doubleword of its own port
		if (s_q.st != deoc_pkg::ST_RUN) begin
			if (port_a_rd && s_q.rd_a < LA) begin
				s_d.dout_a = s_q.bank_a[s_q.rd_a];
				s_d.rd_a = s_q.rd_a + 8'h01;
			end
			if (port_b_rd && s_q.rd_b < LB) begin
				s_d.dout_b = s_q.bank_b[s_q.rd_b];
				s_d.rd_b = s_q.rd_b + 8'h01;
			end
		end
		// restore: words land in the order they were queued
		if (fifo_out_valid && fifo_out_ready) begin
			if (fifo_out_data[W] && s_q.wr_b < LB) begin
				s_d.bank_b[s_q.wr_b] = fifo_out_data[W-1:0];
				s_d.wr_b = s_q.wr_b + 8'h01;
			end else if (!fifo_out_data[W] && s_q.wr_a < LA) begin
				s_d.bank_a[s_q.wr_a] = fifo_out_data[W-1:0];
				s_d.wr_a = s_q.wr_a + 8'h01;
			end
		end
		if (eng_we) begin
			if (eng_sel_b && eng_idx < LB) begin
				s_d.bank_b[eng_idx] = eng_wdata;
			end else if (!eng_sel_b && eng_idx < LA) begin
				s_d.bank_a[eng_idx] = eng_wdata;
			end
		end
		s_d.eng_out = eng_sel_b ? s_q.bank_b[eng_idx] : s_q.bank_a[eng_idx];

		// full save read out: engine drops back to idle with suspend and halted cleared; status flags and irq enables keep their values
		if (s_d.rd_a == LA && s_d.rd_b == LB) begin
			s_d.st = deoc_pkg::ST_IDLE;
			s_d.busy = 1'b0;
			s_d.susp = 1'b0;
			s_d.halted = 1'b0;
			s_d.rd_a = deoc_pkg::PTR_RESET;
			s_d.rd_b = deoc_pkg::PTR_RESET;
		end
		// full restore: operation waits halted until suspend is cleared
		if (s_d.wr_a == LA && s_d.wr_b == LB) begin
			s_d.st = deoc_pkg::ST_HALTED;
			s_d.halted = 1'b1;
			s_d.susp = 1'b1;
			s_d.wr_a = deoc_pkg::PTR_RESET;
			s_d.wr_b = deoc_pkg::PTR_RESET;
		end

		// terminate waits for the memory cycle so no half write reaches memory
		if (s_q.abort && !mem_busy) begin
			op_end = (s_q.st != deoc_pkg::ST_IDLE);
			s_d.st = deoc_pkg::ST_IDLE;
			s_d.abort = 1'b0;
			s_d.busy = 1'b0;
			s_d.susp = 1'b0;
			s_d.halted = 1'b0;
			s_d.en_done = 1'b0;
			s_d.en_rej = 1'b0;
			s_d.rd_a = deoc_pkg::PTR_RESET;
			s_d.rd_b = deoc_pkg::PTR_RESET;
			s_d.wr_a = deoc_pkg::PTR_RESET;
			s_d.wr_b = deoc_pkg::PTR_RESET;
		end

		set_done = op_end;
		// set wins over a clear in the same cycle
		s_d.done = set_done || (s_q.done && !clr_done);
		s_d.rej = set_rej || (s_q.rej && !clr_rej);
		s_d.irq = (s_d.done && s_d.en_done) || (s_d.rej && s_d.en_rej);
		// held in a flop so the datapath never sees a glitch while terminate lands
		s_d.run = s_d.busy && !s_d.abort;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q <= '0;
			len_a <= deoc_pkg::PTR_RESET;
			len_b <= deoc_pkg::PTR_RESET;
			ctrl_rdata <= deoc_pkg::CTRL_RESET;
			restore_ready <= 1'b0;
		end else if (clk_en) begin
			s_q <= s_d;
			len_a <= LA;
			len_b <= LB;
			ctrl_rdata <= deoc_pkg::CTRL_RESET;
			ctrl_rdata[deoc_pkg::CTRL_BUSY_BIT] <= s_d.busy;
			ctrl_rdata[deoc_pkg::CTRL_ABORT_BIT] <= s_d.abort;
			ctrl_rdata[deoc_pkg::CTRL_HALTED_BIT] <= s_d.halted;
			ctrl_rdata[deoc_pkg::CTRL_SUSP_BIT] <= s_d.susp;
			// flopped from the fill before this cycle's push, so it leaves no margin for that push
			restore_ready <= fifo_in_ready && (s_d.st != deoc_pkg::ST_RUN);
		end
	end

	assign engine_active_flag = s_q.busy;
	assign halted_flag = s_q.halted;
	assign abort_request = s_q.abort;
	assign done_status = s_q.done;
	assign rej_status = s_q.rej;
	assign irq = s_q.irq;
	assign tlb_flush = s_q.tlb;
	assign run_en = s_q.run;
	assign write_inhibit = s_q.inhibit;
	assign port_a_rdata = s_q.dout_a;
	assign port_b_rdata = s_q.dout_b;
	assign eng_rdata = s_q.eng_out;
endmodule // deoc_op_control
`default_nettype wire

// ### tb/deoc_op_control_sva.sv
// deoc_op_control_sva: port-level checks of the operation control block.
// assumes: bound to deoc_op_control; clk_en stays high around strobes.
`timescale 1ns/10ps
`default_nettype none
module deoc_op_control_sva (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic clk_en, // enable
	input wire logic host_wr, // write
	input wire logic host_wr_ctrl, // ctrl write
	input wire logic host_wr_start, // start
	input wire deoc_pkg::deoc_ctrl_s ctrl_wdata, // ctrl data
	input wire logic mem_busy, // mem cycle
	input wire logic op_last, // last pixel
	input wire deoc_pkg::deoc_pix_s pix, // compare in
	input wire logic [7:0] ctrl_rdata, // ctrl read
	input wire logic engine_active_flag, // busy
	input wire logic halted_flag, // halted
	input wire logic abort_request, // abort
	input wire logic done_status, // done
	input wire logic rej_status, // rejected
	input wire logic irq, // interrupt
	input wire logic tlb_flush, // flush
	input wire logic write_inhibit // inhibit
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// bit n of each mask is the inhibit of code n for d>v, d==v, d<v
	function automatic logic inh(logic [2:0] c, logic [7:0] d, logic [7:0] v);
		logic [7:0] m;
		m = (d > v) ? 8'h63 : ((d == v) ? 8'ha5 : 8'hc9);
		return m[c];
	endfunction
	AST_INHIBIT: assert property (
		pix.valid && clk_en |=>
		write_inhibit == inh($past(pix.cond), $past(pix.dest), $past(pix.value)))
		else $error("inhibit wrong");
	AST_START: assert property (
		host_wr && host_wr_start && clk_en && !engine_active_flag && !halted_flag
		&& !abort_request |=> engine_active_flag) else $error("no start");
	AST_DONE: assert property (
		engine_active_flag && op_last && clk_en && !host_wr
		|=> done_status && !engine_active_flag) else $error("no completion");
	AST_IRQ: assert property (
		irq |-> done_status || rej_status)
		else $error("irq without status");
	AST_CTRL_BITS: assert property (
		ctrl_rdata[7] == engine_active_flag && ctrl_rdata[5] == abort_request
		&& ctrl_rdata[4] == halted_flag) else $error("ctrl bits wrong");
	AST_REJ: assert property (
		host_wr && !host_wr_ctrl && engine_active_flag && clk_en |=> rej_status)
		else $error("no reject");
	AST_CTRL_OK: assert property (
		host_wr && host_wr_ctrl && !rej_status && clk_en |=> !rej_status)
		else $error("ctrl write rejected");
	AST_HALT: assert property (
		$rose(halted_flag) && tlb_flush |-> !$past(mem_busy)) else $error("halt early");
	AST_FLUSH: assert property (
		tlb_flush |-> (halted_flag && !$past(halted_flag)) ##1 !tlb_flush)
		else $error("flush wrong");
	AST_RESUME: assert property (
		halted_flag && !abort_request && host_wr && host_wr_ctrl && !ctrl_wdata.suspend
		&& !ctrl_wdata.abort && clk_en |-> ##[1:2] engine_active_flag)
		else $error("no resume");
	AST_ABORT: assert property (
		abort_request && !mem_busy && clk_en
		|=> !abort_request && !engine_active_flag && !halted_flag) else $error("abort stuck");
endmodule // deoc_op_control_sva
bind deoc_op_control deoc_op_control_sva u_deoc_op_control_sva (.clk, .reset_n, .clk_en,
	.host_wr, .host_wr_ctrl, .host_wr_start, .ctrl_wdata, .mem_busy, .op_last, .pix,
	.ctrl_rdata, .engine_active_flag, .halted_flag, .abort_request, .done_status,
	.rej_status, .irq, .tlb_flush, .write_inhibit);
`default_nettype wire

// ### tb/tb_deoc_op_control.sv
// tb_deoc_op_control: directed host sequences for the operation control block.
// assumes: package and design compiled first; checker bound from its own file.
`timescale 1ns/10ps
`default_nettype none
module tb_deoc_op_control;
	localparam int LEN = 16;
	localparam logic [7:0] TBL [3] = '{8'h63, 8'ha5, 8'hc9};
	logic clk, reset_n, clk_en, host_wr, host_wr_ctrl, host_wr_start;
	deoc_pkg::deoc_ctrl_s ctrl_wdata;
	deoc_pkg::deoc_pix_s pix;
	logic irq_en_wr, en_d, en_r, clr_done, clr_rej, mem_busy, op_last;
	logic a_rd, b_rd, a_wr, b_wr, eng_we, eng_sel_b, busy, halted, abort_req;
	logic done_st, rej_st, irq, tlb_flush, inhibit, rst_ready, run_en;
	logic [31:0] port_wdata, eng_wdata, a_rdata, b_rdata, eng_rdata;
	logic [7:0] eng_idx, ctrl_rdata, len_a, len_b;
	int failures, samples_checked;
	deoc_op_control #(.LEN_A(LEN), .LEN_B(LEN), .FIFO_DEPTH(8)) u_deoc_op_control (
		.clk, .reset_n, .clk_en, .host_wr, .host_wr_ctrl, .host_wr_start, .ctrl_wdata,
		.irq_en_wr, .irq_en_done_in(en_d), .irq_en_rej_in(en_r), .clr_done, .clr_rej,
		.mem_busy, .op_last, .pix, .port_a_rd(a_rd), .port_b_rd(b_rd), .port_a_wr(a_wr),
		.port_b_wr(b_wr), .port_wdata, .eng_we, .eng_sel_b, .eng_idx, .eng_wdata,
		.ctrl_rdata, .engine_active_flag(busy), .halted_flag(halted),
		.abort_request(abort_req), .done_status(done_st), .rej_status(rej_st), .irq,
		.tlb_flush, .run_en, .write_inhibit(inhibit), .port_a_rdata(a_rdata),
		.port_b_rdata(b_rdata), .restore_ready(rst_ready), .len_a, .len_b, .eng_rdata);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic nxt(input int n = 1);
		repeat (n) @(negedge clk);
	endtask
	// flags packed as busy, halted, abort, done, rejected, irq
	task automatic flg(input logic [5:0] e);
		chk("flags", {26'h0, e}, {26'h0, busy, halted, abort_req, done_st, rej_st, irq});
	endtask
	// an idle edge first, so back-to-back calls never drop and raise a strobe at once
	task automatic pulse(ref logic s);
		nxt();
		s = 1'b1;
		nxt();
		s = 1'b0;
	endtask
	task automatic hw(input logic ctl, input logic st, input logic sus, input logic ab);
		nxt();
		{host_wr, host_wr_ctrl, host_wr_start, ctrl_wdata} = {1'b1, ctl, st, sus, ab};
		nxt();
		{host_wr, host_wr_ctrl, host_wr_start, ctrl_wdata} = 0;
	endtask
	task automatic ien(input logic d, input logic r);
		en_d = d;
		en_r = r;
		pulse(irq_en_wr);
	endtask
	// strobes drop while the buffer is full so no word is offered twice
	task automatic wait_ready();
		if (rst_ready !== 1'b1) {host_wr, a_wr, b_wr} = 0;
		for (int n = 0; n < 30 && rst_ready !== 1'b1; n++) nxt();
		chk("restore ready", 1, rst_ready);
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		wrap_up();
	end
	initial begin
		{reset_n, host_wr, host_wr_ctrl, host_wr_start, ctrl_wdata, irq_en_wr, en_d} = 0;
		{en_r, clr_done, clr_rej, mem_busy, op_last, pix, a_rd, b_rd, a_wr, b_wr} = 0;
		{port_wdata, eng_we, eng_sel_b, eng_idx, eng_wdata, failures, samples_checked} = 0;
		clk_en = 1'b1;
		nxt(20);
		reset_n = 1'b1;
		nxt(2);
		flg(6'h00);
		chk("len a", LEN, len_a);
		chk("len b", LEN, len_b);
		for (int c = 0; c < 24; c++) begin
			pix = '{1'b1, c[2:0], 8'h40, 8'h3f + {6'h0, c[4:3]}};
			nxt();
			chk("inhibit", {31'h0, TBL[c / 8][c % 8]}, {31'h0, inhibit});
		end
		pix = '0;
		ien(1'b1, 1'b1);
		hw(0, 0, 0, 0);
		flg(6'h00);
		hw(0, 1, 0, 0);
		flg(6'h20);
		chk("run en", 1, run_en);
		chk("ctrl", 8'h80, ctrl_rdata);
		hw(1, 0, 0, 0);
		flg(6'h20);
		hw(0, 0, 0, 0);
		flg(6'h23);
		pulse(clr_rej);
		flg(6'h20);
		clk_en = 1'b0;
		pulse(op_last);
		clk_en = 1'b1;
		flg(6'h20);
		pulse(op_last);
		flg(6'h05);
		pulse(clr_done);
		flg(6'h00);
		ien(1'b0, 1'b0);
		hw(0, 1, 0, 0);
		pulse(op_last);
		flg(6'h04);
		pulse(clr_done);
		hw(0, 1, 0, 0);
		mem_busy = 1'b1;
		hw(1, 0, 1, 0);
		nxt(3);
		flg(6'h20);
		mem_busy = 1'b0;
		nxt();
		flg(6'h10);
		chk("flush", 1, tlb_flush);
		chk("run en", 0, run_en);
		chk("ctrl", 8'h18, ctrl_rdata);
		for (int i = 0; i < 2 * LEN; i++) begin
			{eng_we, eng_sel_b, eng_idx, eng_wdata} = {1'b1, i[4], 4'h0, i[3:0], 32'ha5a5_0000 + i};
			nxt();
		end
		eng_we = 1'b0;
		// ports read in turn, back to back, exactly the length counts
		for (int i = 0; i < 2 * LEN; i++) begin
			{a_rd, b_rd} = {!i[0], i[0]};
			nxt();
			chk("save", 32'ha5a5_0000 + i[0] * LEN + i / 2, i[0] ? b_rdata : a_rdata);
		end
		{a_rd, b_rd} = 0;
		chk("ctrl", 8'h00, ctrl_rdata);
		for (int i = 0; i < 2 * LEN; i++) begin
			wait_ready();
			{host_wr, a_wr, b_wr, port_wdata} = {1'b1, !i[0], i[0], 32'h5a00_0000 + i};
			nxt();
		end
		{host_wr, a_wr, b_wr} = 0;
		for (int n = 0; n < 30 && halted !== 1'b1; n++) nxt();
		flg(6'h10);
		chk("ctrl", 8'h18, ctrl_rdata);
		for (int i = 0; i < 2 * LEN; i++) begin
			{eng_sel_b, eng_idx} = {i[0], 3'h0, i[5:1]};
			nxt();
			chk("restored", 32'h5a00_0000 + i, eng_rdata);
		end
		hw(1, 0, 0, 0);
		nxt();
		flg(6'h20);
		ien(1'b1, 1'b1);
		hw(1, 0, 1, 0);
		nxt();
		flg(6'h10);
		// a start while halted is ignored until a terminate
		hw(0, 1, 0, 0);
		flg(6'h10);
		mem_busy = 1'b1;
		hw(1, 0, 1, 1);
		flg(6'h18);
		mem_busy = 1'b0;
		nxt(2);
		flg(6'h04);
		chk("ctrl", 8'h00, ctrl_rdata);
		pulse(clr_done);
		hw(0, 1, 0, 0);
		flg(6'h20);
		pulse(op_last);
		flg(6'h04);
		wrap_up();
	end
endmodule // tb_deoc_op_control
`default_nettype wire
